// file: core/bpit_btb_mem.sv
// Storage of the branch_target_buffer: one read port, one write port
// Assumes the caller tolerates read data one cycle after the request
`timescale 1ns/1ns
module bpit_btb_mem (
    input wire logic i_sys_clk, // Core clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_rd_en, // Read request
    input wire logic [bpit_pkg::IDX_W-1:0] i_rd_idx, // Read index
    output bpit_pkg::bpit_btb_t o_rd_ff, // Registered read data
    input wire logic i_we, // Write strobe
    input wire logic [bpit_pkg::IDX_W-1:0] i_wr_idx, // Write index
    input wire bpit_pkg::bpit_btb_t i_wr_data // Entry to write
);
    bpit_pkg::bpit_btb_t ent_ff [bpit_pkg::BTB_N];

    // Entries start empty so nothing is predicted before its first taken pass
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < bpit_pkg::BTB_N; i++) begin
                ent_ff[i] <= '0;
            end
        end else if (i_we) begin
            ent_ff[i_wr_idx] <= i_wr_data;
        end
    end

    // Read holds its value while not enabled; a same-cycle write is not seen
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_ff <= '0;
        end else if (i_rd_en) begin
            o_rd_ff <= ent_ff[i_rd_idx];
        end
    end
endmodule // bpit_btb_mem

// file: core/bpit_issue_ctl.sv
// Issue slot timing and branch prediction for an in-order core
// Assumes decode gives resolved outcomes; fetch obeys o_redirect_ff
`timescale 1ns/1ns
module bpit_issue_ctl (
    input wire logic i_sys_clk, // Core clock, 25 MHz
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_dec_valid, // Decoded instruction offered
    input wire bpit_pkg::bpit_dec_t i_dec, // Decoded instruction
    output logic o_in_ready_ff, // Slot takes i_dec this cycle
    output logic o_issue_ff, // Pulse: an instruction issued
    output logic [bpit_pkg::PC_W-1:0] o_issue_pc_ff, // Its address
    output bpit_pkg::bpit_lat_t o_issue_lat_ff, // Its issue latency
    output logic o_pred_taken_ff, // Buffer predicted taken
    output logic o_mispredict_ff, // Relative jump direction was wrong
    output logic o_redirect_ff // Fetch must take the resolved path
);
    // Latency of a data processing operation
    function automatic bpit_pkg::bpit_lat_t dp_lat(input bpit_pkg::bpit_dec_t d);
        return d.shift_reg ? bpit_pkg::LAT_SHIFT : bpit_pkg::LAT_ONE;
    endfunction

    // A reader waits while its producer is pending; doubling sources wait one more
    function automatic logic stall_fn(
        input bpit_pkg::bpit_dec_t d,
        input bpit_pkg::bpit_lat_t rem,
        input logic [bpit_pkg::REG_W-1:0] pdst,
        input logic pv
    );
        logic hit_a;
        logic hit_b;
        hit_a = d.rd_a && (d.src_a == pdst)
            && (rem > (d.spec_a ? bpit_pkg::LAT_ZERO : bpit_pkg::LAT_ONE));
        hit_b = d.rd_b && (d.src_b == pdst)
            && (rem > (d.spec_b ? bpit_pkg::LAT_ZERO : bpit_pkg::LAT_ONE));
        return pv && (hit_a || hit_b);
    endfunction

    // Minimum issue latency; compact set pays one cycle more when redirected
    function automatic bpit_pkg::bpit_lat_t issue_lat(
        input bpit_pkg::bpit_dec_t d,
        input logic mis
    );
        bpit_pkg::bpit_lat_t pen;
        bpit_pkg::bpit_lat_t ext;
        bpit_pkg::bpit_lat_t dpl;
        bpit_pkg::bpit_lat_t over;
        bpit_pkg::bpit_lat_t lat;
        pen = d.compact ? bpit_pkg::PEN_CMP : bpit_pkg::PEN_STD;
        ext = pen - bpit_pkg::PEN_STD;
        dpl = dp_lat(d);
        over = (d.numreg > bpit_pkg::LDM_FREE) ? d.numreg - bpit_pkg::LDM_FREE
            : bpit_pkg::LAT_ZERO;
        // No addressing mode input exists, so none can add cycles
        case (d.kind)
            bpit_pkg::KIND_REL: begin
                lat = mis ? bpit_pkg::LAT_ONE + pen : bpit_pkg::LAT_ONE;
            end
            bpit_pkg::KIND_REG: begin
                lat = d.taken ? bpit_pkg::LAT_ONE + pen : bpit_pkg::LAT_ONE;
            end
            bpit_pkg::KIND_JLX: begin
                lat = bpit_pkg::LAT_ONE + pen;
            end
            bpit_pkg::KIND_DP: begin
                lat = dpl;
            end
            bpit_pkg::KIND_DP_PC: begin
                lat = d.taken ? dpl + pen : dpl;
            end
            bpit_pkg::KIND_LD_PC: begin
                lat = d.taken ? bpit_pkg::LDPC_T + ext : bpit_pkg::LDPC_NT;
            end
            bpit_pkg::KIND_LDM_PC: begin
                lat = d.taken ? bpit_pkg::LDM_T_BASE + ext + over
                    : bpit_pkg::LDM_NT_BASE + d.numreg;
            end
            default: begin
                lat = bpit_pkg::LAT_ONE;
            end
        endcase
        return lat;
    endfunction

    logic hold_v_ff;
    bpit_pkg::bpit_dec_t hold_ff;
    bpit_pkg::bpit_lat_t gap_ff;
    bpit_pkg::bpit_lat_t rem_ff;
    logic [bpit_pkg::REG_W-1:0] pdst_ff;
    logic pv_ff;
    bpit_pkg::bpit_btb_t btb_rd;
    bpit_pkg::bpit_btb_t btb_wd;

    logic load;
    logic is_rel;
    logic btb_hit;
    logic pred_taken;
    logic mis;
    logic redirect;
    logic stall_now;
    logic issue;
    logic btb_we;
    logic dp_wr;
    bpit_pkg::bpit_lat_t lat_now;
    logic nxt_hold_v;
    bpit_pkg::bpit_dec_t nxt_hold;
    bpit_pkg::bpit_lat_t nxt_gap;
    bpit_pkg::bpit_lat_t nxt_rem;
    logic [bpit_pkg::REG_W-1:0] nxt_pdst;
    logic nxt_pv;
    logic nxt_ready;

    // Lookup is launched as the instruction enters the slot
    bpit_btb_mem u_btb (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_rd_en(load),
        .i_rd_idx(i_dec.pc[bpit_pkg::TAG_LO-1:bpit_pkg::IDX_LO]),
        .o_rd_ff(btb_rd),
        .i_we(btb_we),
        .i_wr_idx(hold_ff.pc[bpit_pkg::TAG_LO-1:bpit_pkg::IDX_LO]),
        .i_wr_data(btb_wd)
    );

    // Prediction and resolution of the instruction in the slot
    assign load = i_dec_valid && o_in_ready_ff;
    assign is_rel = (hold_ff.kind == bpit_pkg::KIND_REL);
    assign btb_hit = btb_rd.valid && (btb_rd.tag == hold_ff.pc[bpit_pkg::PC_W-1:bpit_pkg::TAG_LO]);
    assign pred_taken = is_rel && btb_hit && btb_rd.ctr[bpit_pkg::CTR_DIR];
    assign mis = is_rel && (pred_taken != hold_ff.taken);
    assign redirect = mis || (!is_rel && hold_ff.taken
        && (hold_ff.kind != bpit_pkg::KIND_DP)
        && (hold_ff.kind != bpit_pkg::KIND_OTHER))
        || (hold_ff.kind == bpit_pkg::KIND_JLX);
    assign stall_now = stall_fn(hold_ff, rem_ff, pdst_ff, pv_ff);
    assign issue = hold_v_ff && (gap_ff == bpit_pkg::LAT_ZERO) && !stall_now;
    assign lat_now = issue_lat(hold_ff, mis);
    assign dp_wr = (hold_ff.kind == bpit_pkg::KIND_DP) && hold_ff.wr_dst;

    // Buffer update; never-taken branches leave no trace
    assign btb_we = issue && is_rel && (btb_hit || hold_ff.taken);
    always_comb begin
        btb_wd.valid = 1'b1;
        btb_wd.tag = hold_ff.pc[bpit_pkg::PC_W-1:bpit_pkg::TAG_LO];
        if (!btb_hit) begin
            btb_wd.ctr = bpit_pkg::CTR_ALLOC;
        end else if (hold_ff.taken) begin
            btb_wd.ctr = (btb_rd.ctr == bpit_pkg::CTR_MAX) ? btb_rd.ctr
                : btb_rd.ctr + 2'h1;
        end else begin
            btb_wd.ctr = (btb_rd.ctr == bpit_pkg::CTR_MIN) ? btb_rd.ctr
                : btb_rd.ctr - 2'h1;
        end
    end

    // Next state of the slot, the gap counter and the scoreboard
    always_comb begin
        nxt_hold_v = load || (hold_v_ff && !issue);
        nxt_hold = load ? i_dec : hold_ff;
        if (issue) begin
            nxt_gap = lat_now - bpit_pkg::LAT_ONE;
        end else if (gap_ff != bpit_pkg::LAT_ZERO) begin
            nxt_gap = gap_ff - bpit_pkg::LAT_ONE;
        end else begin
            nxt_gap = bpit_pkg::LAT_ZERO;
        end
        // Result latency equals issue latency for data processing
        if (issue && dp_wr) begin
            nxt_rem = dp_lat(hold_ff);
        end else if (rem_ff != bpit_pkg::LAT_ZERO) begin
            nxt_rem = rem_ff - bpit_pkg::LAT_ONE;
        end else begin
            nxt_rem = bpit_pkg::LAT_ZERO;
        end
        nxt_pdst = (issue && dp_wr) ? hold_ff.dst : pdst_ff;
        nxt_pv = (issue && dp_wr) || (pv_ff && (nxt_rem != bpit_pkg::LAT_ZERO));
        // Ready looks one cycle ahead so back-to-back issue needs no bubble
        nxt_ready = !nxt_hold_v || ((nxt_gap == bpit_pkg::LAT_ZERO)
            && !stall_fn(nxt_hold, nxt_rem, nxt_pdst, nxt_pv));
    end

    // Slot holding register
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hold_v_ff <= 1'b0;
            hold_ff <= '0;
            o_in_ready_ff <= 1'b1;
        end else begin
            hold_v_ff <= nxt_hold_v;
            hold_ff <= nxt_hold;
            o_in_ready_ff <= nxt_ready;
        end
    end

    // Issue spacing counter
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gap_ff <= bpit_pkg::LAT_ZERO;
        end else begin
            gap_ff <= nxt_gap;
        end
    end

    // One pending producer is enough: in-order issue retires older ones first
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rem_ff <= bpit_pkg::LAT_ZERO;
            pdst_ff <= '0;
            pv_ff <= 1'b0;
        end else begin
            rem_ff <= nxt_rem;
            pdst_ff <= nxt_pdst;
            pv_ff <= nxt_pv;
        end
    end

    // Issue report, one cycle after the issue clock
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_issue_ff <= 1'b0;
            o_issue_pc_ff <= '0;
            o_issue_lat_ff <= bpit_pkg::LAT_ZERO;
            o_pred_taken_ff <= 1'b0;
            o_mispredict_ff <= 1'b0;
            o_redirect_ff <= 1'b0;
        end else begin
            o_issue_ff <= issue;
            o_issue_pc_ff <= issue ? hold_ff.pc : o_issue_pc_ff;
            o_issue_lat_ff <= issue ? lat_now : o_issue_lat_ff;
            o_pred_taken_ff <= issue && pred_taken;
            o_mispredict_ff <= issue && mis;
            o_redirect_ff <= issue && redirect;
        end
    end

    // Allocation only for a taken branch
    alloc_taken_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (btb_we && !btb_hit) |-> hold_ff.taken)
        else $error("buffer entry allocated for an untaken branch");

    // No history, no taken prediction
    predict_hist_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (issue && !btb_hit) |=> !o_pred_taken_ff)
        else $error("taken prediction without a buffer entry");

    // Correct prediction leaves the next cycle free
    correct_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (issue && is_rel && !mis) |=> (gap_ff == bpit_pkg::LAT_ZERO))
        else $error("correct prediction delayed the next issue");

    // Mispredict gap equals the penalty
    mis_penalty_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (issue && is_rel && mis) |=> o_mispredict_ff && o_redirect_ff
        && (gap_ff == ($past(hold_ff.compact) ? bpit_pkg::PEN_CMP : bpit_pkg::PEN_STD)))
        else $error("mispredict penalty wrong");

    // Taken register jump in the standard set costs five
    reg_jump_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (issue && hold_ff.kind == bpit_pkg::KIND_REG && hold_ff.taken && !hold_ff.compact)
        |=> (o_issue_lat_ff == bpit_pkg::LAT_ONE + bpit_pkg::PEN_STD) && o_redirect_ff)
        else $error("register jump latency wrong");

    // Data processing to the counter, taken
    dp_counter_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (issue && hold_ff.kind == bpit_pkg::KIND_DP_PC && hold_ff.taken && !hold_ff.compact)
        |=> (o_issue_lat_ff == bpit_pkg::PEN_STD
            + ($past(hold_ff.shift_reg) ? bpit_pkg::LAT_SHIFT : bpit_pkg::LAT_ONE)))
        else $error("counter write latency wrong");

    // Counter load spacing
    ld_counter_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (issue && hold_ff.kind == bpit_pkg::KIND_LD_PC && !hold_ff.compact)
        |=> (o_issue_lat_ff == ($past(hold_ff.taken) ? bpit_pkg::LDPC_T : bpit_pkg::LDPC_NT))
        && !o_pred_taken_ff)
        else $error("counter load latency wrong");

    // Register-shifted operation blocks exactly one following cycle
    dp_shift_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (issue && hold_ff.kind == bpit_pkg::KIND_DP && hold_ff.shift_reg)
        |=> (gap_ff == bpit_pkg::LAT_ONE) ##1 (gap_ff == bpit_pkg::LAT_ZERO))
        else $error("shifted operation spacing wrong");

    // Doubling or shift source of a fresh result waits one extra cycle
    extra_cycle_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (issue && dp_wr && !hold_ff.shift_reg) |=> !(issue && hold_ff.rd_a
        && hold_ff.spec_a && (hold_ff.src_a == $past(hold_ff.dst))))
        else $error("special consumer issued too early");
endmodule // bpit_issue_ctl

// file: include/bpit_pkg.sv
// Shared types and timing constants for the branch predict / issue timing block
// Assumes one in-order issue slot fed by a decoder that knows each outcome
package bpit_pkg;
    localparam int PC_W = 32;
    localparam int IDX_W = 4;
    localparam int IDX_LO = 2;
    localparam int TAG_LO = IDX_LO + IDX_W;
    localparam int TAG_W = PC_W - TAG_LO;
    localparam int BTB_N = 1 << IDX_W;
    localparam int LAT_W = 5;
    localparam int REG_W = 4;
    localparam int CTR_DIR = 1;

    typedef logic [LAT_W-1:0] bpit_lat_t;

    // Cycle figures, all in core clock cycles
    localparam bpit_lat_t LAT_ZERO = 5'h00;
    localparam bpit_lat_t LAT_ONE = 5'h01;
    localparam bpit_lat_t LAT_SHIFT = 5'h02;
    localparam bpit_lat_t PEN_STD = 5'h04;
    localparam bpit_lat_t PEN_CMP = 5'h05;
    localparam bpit_lat_t LDPC_NT = 5'h02;
    localparam bpit_lat_t LDPC_T = 5'h08;
    localparam bpit_lat_t LDM_NT_BASE = 5'h03;
    localparam bpit_lat_t LDM_T_BASE = 5'h0a;
    localparam bpit_lat_t LDM_FREE = 5'h03;

    // Two-bit direction history per buffer entry
    localparam logic [1:0] CTR_ALLOC = 2'h2;
    localparam logic [1:0] CTR_MAX = 2'h3;
    localparam logic [1:0] CTR_MIN = 2'h0;

    typedef enum logic [2:0] {
        KIND_REL = 3'b000,    // relative jump or relative_jump_link
        KIND_REG = 3'b001,    // register_jump, register form of link exchange
        KIND_JLX = 3'b010,    // immediate jump_link_exchange, always taken
        KIND_DP = 3'b011,     // data processing to an ordinary register
        KIND_DP_PC = 3'b100,  // data processing writing program_counter
        KIND_LD_PC = 3'b101,  // single_word_load to program_counter
        KIND_LDM_PC = 3'b110, // multi_register_load listing program_counter
        KIND_OTHER = 3'b111   // anything else, one cycle
    } bpit_kind_t;

    typedef struct packed {
        bpit_kind_t kind;
        logic compact;          // compact instruction set
        logic shift_reg;        // shift by register or rotate_extend_carry
        logic taken;            // resolved outcome
        logic [PC_W-1:0] pc;
        bpit_lat_t numreg;      // list length, program_counter included
        logic [REG_W-1:0] dst;
        logic wr_dst;
        logic [REG_W-1:0] src_a;
        logic rd_a;
        logic spec_a;           // used as immediate-shift or doubling source
        logic [REG_W-1:0] src_b;
        logic rd_b;
        logic spec_b;
    } bpit_dec_t;

    typedef struct packed {
        logic valid;
        logic [TAG_W-1:0] tag;
        logic [1:0] ctr;
    } bpit_btb_t;
endpackage

// file: testbench/test_branch_predict_issue_timing.sv
// Bench for the issue timing block: offers decoded instructions, checks issue reports
// Assumes reports come in acceptance order, one pulse per instruction
`timescale 1ns/1ns
module test_branch_predict_issue_timing;
    typedef struct packed {
        logic [31:0] pc;
        bpit_pkg::bpit_lat_t lat;
        logic [2:0] pmr; // Predicted, mispredicted, redirect
        logic [4:0] gap; // Report spacing; 0 leaves it unchecked
    } bpit_exp_t;

    logic i_sys_clk;
    logic i_nrst;
    logic i_dec_valid;
    bpit_pkg::bpit_dec_t i_dec;
    logic o_in_ready_ff, o_issue_ff, o_pred_taken_ff, o_mispredict_ff, o_redirect_ff;
    logic [bpit_pkg::PC_W-1:0] o_issue_pc_ff;
    bpit_pkg::bpit_lat_t o_issue_lat_ff;
    bpit_exp_t exp_q[$];
    bpit_pkg::bpit_dec_t dd;
    bpit_pkg::bpit_lat_t wprev = 5'h00; // Latency of the previous writer, spaces the next
    int errors = 0;
    int cmp_count = 0;
    int unsigned cyc = 0;
    int unsigned last_cyc = 0;
    logic [31:0] seed = 32'h00008da7;

    bpit_issue_ctl dut (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_dec_valid(i_dec_valid), .i_dec(i_dec),
        .o_in_ready_ff(o_in_ready_ff), .o_issue_ff(o_issue_ff), .o_issue_pc_ff(o_issue_pc_ff),
        .o_issue_lat_ff(o_issue_lat_ff), .o_pred_taken_ff(o_pred_taken_ff),
        .o_mispredict_ff(o_mispredict_ff), .o_redirect_ff(o_redirect_ff)
    );

    // Free-running 25 MHz core clock
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // Cycle count, used to measure spacing between issue reports
    always @(posedge i_sys_clk) cyc <= cyc + 1;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic bpit_pkg::bpit_dec_t mkd(input bpit_pkg::bpit_kind_t k, input logic cmp,
            input logic sh, input logic tk, input logic [31:0] pc);
        bpit_pkg::bpit_dec_t d;
        d = '0;
        d.kind = k;
        d.compact = cmp;
        d.shift_reg = sh;
        d.taken = tk;
        d.pc = pc;
        return d;
    endfunction

    function automatic bpit_exp_t mke(input logic [31:0] pc, input bpit_pkg::bpit_lat_t lat,
            input logic [2:0] pmr, input logic [4:0] gap);
        bpit_exp_t e;
        e.pc = pc;
        e.lat = lat;
        e.pmr = pmr;
        e.gap = gap;
        return e;
    endfunction

    task automatic fail(input string m);
        errors++;
        $display("Error %0t: %s", $time, m);
    endtask

    task automatic check_issue(input bpit_exp_t e);
        cmp_count++;
        if (o_issue_pc_ff !== e.pc || o_issue_lat_ff !== e.lat
                || {o_pred_taken_ff, o_mispredict_ff, o_redirect_ff} !== e.pmr) begin
            $display("Error %0t: pc %h lat %0d pmr %b, wanted lat %0d pmr %b", $time,
                     o_issue_pc_ff, o_issue_lat_ff,
                     {o_pred_taken_ff, o_mispredict_ff, o_redirect_ff}, e.lat, e.pmr);
            errors++;
        end
    endtask

    task automatic check_gap(input int unsigned got, input logic [4:0] want);
        cmp_count++;
        if (got != 32'(want)) fail("issue spacing differs");
    endtask

    task automatic check_reset();
        cmp_count++;
        if (o_in_ready_ff !== 1'b1 || o_issue_ff !== 1'b0 || o_issue_lat_ff !== 5'h00
                || o_issue_pc_ff !== 32'h0 || o_pred_taken_ff !== 1'b0
                || o_mispredict_ff !== 1'b0 || o_redirect_ff !== 1'b0) fail("reset values");
    endtask

    // Monitor: outputs are settled by the falling edge, so each pulse is seen once
    always @(negedge i_sys_clk) begin
        if (i_nrst === 1'b1 && o_issue_ff === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("issue with no pending note");
            end else begin
                if (exp_q[0].gap != 5'h00) check_gap(cyc - last_cyc, exp_q[0].gap);
                check_issue(exp_q.pop_front());
            end
            last_cyc = cyc;
        end
    end

    // Offer one instruction and hold it until an edge with ready high takes it
    task automatic send(input bpit_pkg::bpit_dec_t d, input bpit_exp_t e);
        int n;
        i_dec_valid = 1'b1;
        i_dec = d;
        exp_q.push_back(e);
        n = 0;
        while (o_in_ready_ff !== 1'b1 && n < 50) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n == 50) fail("offer never taken");
        @(negedge i_sys_clk);
    endtask

    task automatic op(input bpit_pkg::bpit_kind_t k, input logic cmp, input logic sh,
            input logic tk, input logic [31:0] pc, input bpit_pkg::bpit_lat_t lat,
            input logic [2:0] pmr, input logic [4:0] gap);
        send(mkd(k, cmp, sh, tk, pc), mke(pc, lat, pmr, gap));
    endtask

    // Relative jump then two fillers; a filler after a correct guess must follow at once
    task automatic br(input logic [31:0] pc, input logic cmp, input logic tk, input logic pr,
            input logic mis);
        bpit_pkg::bpit_lat_t lat;
        lat = mis ? bpit_pkg::LAT_ONE + (cmp ? bpit_pkg::PEN_CMP : bpit_pkg::PEN_STD)
                  : bpit_pkg::LAT_ONE;
        op(bpit_pkg::KIND_REL, cmp, 1'b0, tk, pc, lat, {pr, mis, mis}, 5'h00);
        op(bpit_pkg::KIND_DP, 1'b0, 1'b0, 1'b0, pc + 32'h4, 5'h01, 3'b000, lat);
        op(bpit_pkg::KIND_DP, 1'b0, 1'b0, 1'b0, pc + 32'h8, 5'h01, 3'b000, 5'h01);
    endtask

    // Counter writers are looked up but never predicted, so no guess and no mispredict flag
    task automatic wr(input bpit_pkg::bpit_kind_t k, input logic cmp, input logic sh,
            input logic tk, input bpit_pkg::bpit_lat_t lat);
        op(k, cmp, sh, tk, 32'h600, lat, {2'b00, tk}, wprev);
        wprev = lat;
    endtask

    task automatic dep(input logic [31:0] pc, input logic [3:0] r, input logic wr_it,
            input logic sh, input logic on_b, input logic spec, input logic [4:0] gap);
        dd = mkd(bpit_pkg::KIND_DP, 1'b0, sh, 1'b0, pc);
        dd.dst = r;
        dd.wr_dst = wr_it;
        dd.src_a = r;
        dd.rd_a = !wr_it && !on_b;
        dd.spec_a = spec && !on_b;
        dd.src_b = r;
        dd.rd_b = !wr_it && on_b;
        dd.spec_b = spec && on_b;
        send(dd, mke(pc, sh ? bpit_pkg::LAT_SHIFT : bpit_pkg::LAT_ONE, 3'b000, gap));
    endtask

    task automatic idle(input string name);
        int n;
        i_dec_valid = 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 100) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n == 100) fail("issue report missing");
        repeat (2) @(negedge i_sys_clk);
        $display("Test %s done", name);
    endtask

    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        fail("watchdog expired");
        complete_run();
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        bpit_pkg::bpit_lat_t prev;
        bpit_pkg::bpit_lat_t n;
        i_nrst = 1'b0;
        i_dec_valid = 1'b0;
        i_dec = '0;
        repeat (4) @(negedge i_sys_clk);
        check_reset();
        i_nrst = 1'b1;
        dep(32'h100, 4'h3, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
        dep(32'h104, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0, 5'h01);
        dep(32'h108, 4'h4, 1'b1, 1'b1, 1'b0, 1'b0, 5'h01);
        dep(32'h10c, 4'h4, 1'b0, 1'b0, 1'b1, 1'b0, 5'h02);
        dep(32'h110, 4'h5, 1'b1, 1'b0, 1'b0, 1'b0, 5'h01);
        dep(32'h114, 4'h5, 1'b0, 1'b0, 1'b0, 1'b1, 5'h02);
        dep(32'h118, 4'h6, 1'b1, 1'b1, 1'b0, 1'b0, 5'h01);
        dep(32'h11c, 4'h6, 1'b0, 1'b0, 1'b1, 1'b1, 5'h03);
        prev = bpit_pkg::LAT_ONE;
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            op(bpit_pkg::KIND_DP, 1'b0, r[0], 1'b0, {r[31:2], 2'b00},
               r[0] ? bpit_pkg::LAT_SHIFT : bpit_pkg::LAT_ONE, 3'b000, prev);
            prev = r[0] ? bpit_pkg::LAT_SHIFT : bpit_pkg::LAT_ONE;
        end
        idle("data processing");
        br(32'h200, 1'b0, 1'b1, 1'b0, 1'b1);
        br(32'h200, 1'b0, 1'b1, 1'b1, 1'b0);
        br(32'h200, 1'b0, 1'b0, 1'b1, 1'b1);
        br(32'h200, 1'b0, 1'b0, 1'b1, 1'b1);
        br(32'h200, 1'b0, 1'b0, 1'b0, 1'b0);
        br(32'h300, 1'b1, 1'b1, 1'b0, 1'b1);
        br(32'h300, 1'b1, 1'b1, 1'b1, 1'b0);
        br(32'h404, 1'b0, 1'b0, 1'b0, 1'b0);
        br(32'h404, 1'b0, 1'b0, 1'b0, 1'b0);
        br(32'h404, 1'b0, 1'b1, 1'b0, 1'b1);
        idle("relative jumps");
        wr(bpit_pkg::KIND_REG, 1'b0, 1'b0, 1'b0, 5'h01);
        wr(bpit_pkg::KIND_REG, 1'b0, 1'b0, 1'b1, 5'h05);
        wr(bpit_pkg::KIND_REG, 1'b0, 1'b0, 1'b1, 5'h05);
        wr(bpit_pkg::KIND_REG, 1'b1, 1'b0, 1'b1, 5'h06);
        wr(bpit_pkg::KIND_JLX, 1'b0, 1'b0, 1'b1, 5'h05);
        wr(bpit_pkg::KIND_JLX, 1'b1, 1'b0, 1'b1, 5'h06);
        wr(bpit_pkg::KIND_DP_PC, 1'b0, 1'b0, 1'b0, 5'h01);
        wr(bpit_pkg::KIND_DP_PC, 1'b0, 1'b1, 1'b0, 5'h02);
        wr(bpit_pkg::KIND_DP_PC, 1'b0, 1'b0, 1'b1, 5'h05);
        wr(bpit_pkg::KIND_DP_PC, 1'b0, 1'b1, 1'b1, 5'h06);
        wr(bpit_pkg::KIND_DP_PC, 1'b1, 1'b0, 1'b1, 5'h06);
        wr(bpit_pkg::KIND_LD_PC, 1'b0, 1'b0, 1'b0, 5'h02);
        wr(bpit_pkg::KIND_LD_PC, 1'b0, 1'b0, 1'b1, 5'h08);
        wr(bpit_pkg::KIND_LD_PC, 1'b1, 1'b0, 1'b1, 5'h09);
        wr(bpit_pkg::KIND_OTHER, 1'b0, 1'b0, 1'b0, 5'h01);
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            n = (i == 0) ? 5'h03 : (i == 1) ? 5'h04 : 5'(r[3:0]) + 5'h01;
            r[4] = (i < 2) ? 1'b1 : r[4];
            prev = r[4] ? bpit_pkg::LDM_T_BASE + (n > 5'h03 ? n - 5'h03 : 5'h00) + 5'(r[5])
                        : bpit_pkg::LDM_NT_BASE + n;
            dd = mkd(bpit_pkg::KIND_LDM_PC, r[5], 1'b0, r[4], 32'h700);
            dd.numreg = n;
            send(dd, mke(32'h700, prev, {2'b00, r[4]}, wprev));
            wprev = prev;
        end
        idle("counter writers");
        br(32'h500, 1'b0, 1'b1, 1'b0, 1'b1);
        br(32'h500, 1'b0, 1'b1, 1'b1, 1'b0);
        idle("learn before reset");
        i_nrst = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        check_reset();
        i_nrst = 1'b1;
        br(32'h500, 1'b0, 1'b1, 1'b0, 1'b1);
        idle("buffer cleared by reset");
        complete_run();
    end
endmodule // test_branch_predict_issue_timing
